/* shared/i2csq_pkg.sv */
// Package: register map, field positions and timing constants for the I2C sequence control block
package i2csq_pkg;
  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] ADDR_SEQ_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_TX_BUF = 4'h2;
  localparam logic [3:0] ADDR_RX_BUF = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_BUSY = 4'h6;
  // Control register field positions
  localparam int BIT_GENERAL_CALL_ENABLE = 7;
  localparam int BIT_ACK_STATUS = 6;
  localparam int BIT_ACK_DATA_VALUE = 5;
  localparam int BIT_ACK_SEQUENCE_ENABLE = 4;
  localparam int BIT_RECEIVE_ENABLE = 3;
  localparam int BIT_STOP_ENABLE = 2;
  localparam int BIT_REPEATED_START_ENABLE = 1;
  localparam int BIT_START_OR_STRETCH_ENABLE = 0;
  localparam logic [7:0] SEQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  // Mode register bits
  localparam int BIT_MODE_MASTER = 0;
  // Interrupt bits
  localparam int IRQ_SEQ_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_GCALL = 2;
  localparam int IRQ_SLAVE_BYTE = 3;
  localparam int IRQ_WIDTH = 4;
  // Serial clock timing
  localparam int CLK_MHZ = 250;
  localparam int QUARTER_NS = 1000;
  localparam int QUARTER_CYCLES = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_RSTART = 4'h3,
    ST_STOP = 4'h2,
    ST_TX = 4'h6,
    ST_TX_ACK = 4'h7,
    ST_RX = 4'h5,
    ST_ACK = 4'h4
  } i2csq_state_t;
endpackage : i2csq_pkg

/* rtl/i2csq_sync.sv */
// Two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/10ps
module i2csq_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : i2csq_sync

/* rtl/i2csq_tick.sv */
// Quarter bit period tick generator for the serial clock
`timescale 1ns/10ps
module i2csq_tick #(
  parameter int COUNT = 250
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  // Tick out
  output logic tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (!run || cnt == 16'(COUNT - 1)) begin
      next_cnt = 16'h0000;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end
  assign tick = run && (cnt == 16'(COUNT - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 16'h0000;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end
endmodule : i2csq_tick

/* rtl/i2csq_top.sv */
// I2C sequence control: master sequences, slave stretching and general call, Avalon-MM registers
// Summary of operation
// - Slave with general call enabled raises interrupt on all-zero address byte.
// - Acknowledge status reads 1 when slave did not acknowledge, else 0.
// - Acknowledge data value is driven in the acknowledge slot; 1 means not-acknowledge.
// - Acknowledge enable runs an acknowledge sequence then clears itself.
// - Receive enable clocks in one byte from the slave.
// - Stop enable generates a Stop condition then clears itself.
// - Repeated start enable generates a Repeated Start then clears itself.
// - Start enable generates a Start condition then clears itself.
// - In slave mode the same bit enables clock stretching after each byte.
// - Requests and buffer writes while busy are ignored, never queued.
// - Upper control byte reads zero and ignores writes.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
module i2csq_top #(
  parameter int QUARTER = i2csq_pkg::QUARTER_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // I2C pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic busy;
  i2csq_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  i2csq_tick #(.COUNT(QUARTER)) u_tick (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(busy),
    .tick(tick)
  );
  // Registers
  logic [7:0] ctrl, next_ctrl;
  logic master, next_master;
  logic [7:0] tx_buf, next_tx_buf;
  logic [7:0] rx_buf, next_rx_buf;
  logic [3:0] irq_stat, next_irq_stat;
  logic [3:0] irq_mask, next_irq_mask;
  logic [31:0] rdata, next_rdata;
  logic ack_phase, next_ack_phase;
  // Engine
  i2csq_pkg::i2csq_state_t st, next_st;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg;
  logic scl_drv, next_scl_drv;
  logic sda_drv, next_sda_drv;
  // Slave receiver
  logic scl_d, sda_d, next_scl_d, next_sda_d;
  logic [3:0] s_cnt, next_s_cnt;
  logic [7:0] s_sh, next_s_sh;
  logic s_active, next_s_active;
  logic s_first, next_s_first;
  logic stretch, next_stretch;
  function automatic logic in_bus(input logic [3:0] a);
    in_bus = (a <= i2csq_pkg::ADDR_BUSY);
  endfunction : in_bus
  logic wr, rd;
  // Writes land on the accepting edge; read data is captured one edge earlier
  assign wr = avs_write && ce && ack_phase;
  assign rd = avs_read && ce && !ack_phase;
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_phase && ce);
  assign busy = (st != i2csq_pkg::ST_IDLE);
  assign avs_readdata = rdata;
  assign irq = |(irq_stat & irq_mask);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drv || stretch;
  assign sda_oe = sda_drv;
  logic req_ok;
  logic [3:0] ev;
  always_comb begin
    next_ctrl = ctrl;
    next_master = master;
    next_tx_buf = tx_buf;
    next_rx_buf = rx_buf;
    next_irq_mask = irq_mask;
    next_rdata = rdata;
    next_ack_phase = 1'b0;
    next_st = st;
    next_ph = ph;
    next_bitn = bitn;
    next_shreg = shreg;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    next_scl_d = scl_s;
    next_sda_d = sda_s;
    next_s_cnt = s_cnt;
    next_s_sh = s_sh;
    next_s_active = s_active;
    next_s_first = s_first;
    next_stretch = stretch;
    ev = 4'h0;
    req_ok = !busy && master;
    if (avs_read || avs_write) begin
      next_ack_phase = !ack_phase;
    end
    if (rd) begin
      next_rdata = 32'h0000_0000;
      case (avs_address)
        i2csq_pkg::ADDR_SEQ_CTRL: next_rdata[7:0] = ctrl;
        i2csq_pkg::ADDR_MODE: next_rdata[i2csq_pkg::BIT_MODE_MASTER] = master;
        i2csq_pkg::ADDR_TX_BUF: next_rdata[7:0] = tx_buf;
        i2csq_pkg::ADDR_RX_BUF: next_rdata[7:0] = rx_buf;
        i2csq_pkg::ADDR_IRQ_STATUS: next_rdata[3:0] = irq_stat;
        i2csq_pkg::ADDR_IRQ_MASK: next_rdata[3:0] = irq_mask;
        i2csq_pkg::ADDR_BUSY: next_rdata[0] = busy;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr && avs_byteenable[0] && in_bus(avs_address)) begin
      case (avs_address)
        i2csq_pkg::ADDR_SEQ_CTRL: begin
          next_ctrl[i2csq_pkg::BIT_GENERAL_CALL_ENABLE] = avs_writedata[i2csq_pkg::BIT_GENERAL_CALL_ENABLE];
          next_ctrl[i2csq_pkg::BIT_ACK_DATA_VALUE] = avs_writedata[i2csq_pkg::BIT_ACK_DATA_VALUE];
          if (!master) begin
            next_ctrl[i2csq_pkg::BIT_START_OR_STRETCH_ENABLE] =
              avs_writedata[i2csq_pkg::BIT_START_OR_STRETCH_ENABLE];
          end else if (req_ok) begin
            next_ctrl[4:0] = avs_writedata[4:0];
          end
        end
        i2csq_pkg::ADDR_MODE: next_master = avs_writedata[i2csq_pkg::BIT_MODE_MASTER];
        i2csq_pkg::ADDR_TX_BUF: begin
          if (!busy) begin
            next_tx_buf = avs_writedata[7:0];
          end
        end
        i2csq_pkg::ADDR_IRQ_MASK: next_irq_mask = avs_writedata[3:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // Master engine, one quarter-bit phase per tick
    if (!busy && master) begin
      next_ph = 2'd0;
      if (next_ctrl[i2csq_pkg::BIT_START_OR_STRETCH_ENABLE]) begin
        next_st = i2csq_pkg::ST_START;
      end else if (next_ctrl[i2csq_pkg::BIT_REPEATED_START_ENABLE]) begin
        next_st = i2csq_pkg::ST_RSTART;
      end else if (next_ctrl[i2csq_pkg::BIT_STOP_ENABLE]) begin
        next_st = i2csq_pkg::ST_STOP;
      end else if (next_ctrl[i2csq_pkg::BIT_RECEIVE_ENABLE]) begin
        next_st = i2csq_pkg::ST_RX;
        next_bitn = 4'd0;
      end else if (next_ctrl[i2csq_pkg::BIT_ACK_SEQUENCE_ENABLE]) begin
        next_st = i2csq_pkg::ST_ACK;
      end else if (wr && avs_address == i2csq_pkg::ADDR_TX_BUF && avs_byteenable[0]) begin
        next_st = i2csq_pkg::ST_TX;
        next_bitn = 4'd0;
        next_shreg = avs_writedata[7:0];
      end
    end else if (busy && tick) begin
      next_ph = ph + 2'd1;
      case (st)
        i2csq_pkg::ST_START: begin
          if (ph == 2'd0) next_sda_drv = 1'b1;
          if (ph == 2'd1) next_scl_drv = 1'b1;
          if (ph == 2'd3) begin
            next_st = i2csq_pkg::ST_IDLE;
            next_ctrl[i2csq_pkg::BIT_START_OR_STRETCH_ENABLE] = 1'b0;
            ev[i2csq_pkg::IRQ_SEQ_DONE] = 1'b1;
          end
        end
        i2csq_pkg::ST_RSTART: begin
          if (ph == 2'd0) next_sda_drv = 1'b0;
          if (ph == 2'd1) next_scl_drv = 1'b0;
          if (ph == 2'd2) next_sda_drv = 1'b1;
          if (ph == 2'd3) begin
            next_scl_drv = 1'b1;
            next_st = i2csq_pkg::ST_IDLE;
            next_ctrl[i2csq_pkg::BIT_REPEATED_START_ENABLE] = 1'b0;
            ev[i2csq_pkg::IRQ_SEQ_DONE] = 1'b1;
          end
        end
        i2csq_pkg::ST_STOP: begin
          if (ph == 2'd0) next_sda_drv = 1'b1;
          if (ph == 2'd1) next_scl_drv = 1'b0;
          if (ph == 2'd2) next_sda_drv = 1'b0;
          if (ph == 2'd3) begin
            next_st = i2csq_pkg::ST_IDLE;
            next_ctrl[i2csq_pkg::BIT_STOP_ENABLE] = 1'b0;
            ev[i2csq_pkg::IRQ_SEQ_DONE] = 1'b1;
          end
        end
        i2csq_pkg::ST_TX, i2csq_pkg::ST_TX_ACK: begin
          if (ph == 2'd0) begin
            next_sda_drv = (st == i2csq_pkg::ST_TX) ? !shreg[7] : 1'b0;
          end
          if (ph == 2'd1) next_scl_drv = 1'b0;
          if (ph == 2'd2 && st == i2csq_pkg::ST_TX_ACK) begin
            next_ctrl[i2csq_pkg::BIT_ACK_STATUS] = sda_s;
          end
          if (ph == 2'd3) begin
            next_scl_drv = 1'b1;
            if (st == i2csq_pkg::ST_TX_ACK) begin
              next_st = i2csq_pkg::ST_IDLE;
              ev[i2csq_pkg::IRQ_SEQ_DONE] = 1'b1;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_bitn = bitn + 4'd1;
              if (bitn == 4'd7) next_st = i2csq_pkg::ST_TX_ACK;
            end
          end
        end
        i2csq_pkg::ST_RX: begin
          if (ph == 2'd0) next_sda_drv = 1'b0;
          if (ph == 2'd1) next_scl_drv = 1'b0;
          if (ph == 2'd2) next_shreg = {shreg[6:0], sda_s};
          if (ph == 2'd3) begin
            next_scl_drv = 1'b1;
            next_bitn = bitn + 4'd1;
            if (bitn == 4'd7) begin
              next_rx_buf = shreg;
              next_st = i2csq_pkg::ST_IDLE;
              next_ctrl[i2csq_pkg::BIT_RECEIVE_ENABLE] = 1'b0;
              ev[i2csq_pkg::IRQ_RX_DONE] = 1'b1;
            end
          end
        end
        i2csq_pkg::ST_ACK: begin
          if (ph == 2'd0) next_sda_drv = !ctrl[i2csq_pkg::BIT_ACK_DATA_VALUE];
          if (ph == 2'd1) next_scl_drv = 1'b0;
          if (ph == 2'd3) begin
            next_scl_drv = 1'b1;
            next_st = i2csq_pkg::ST_IDLE;
            next_ctrl[i2csq_pkg::BIT_ACK_SEQUENCE_ENABLE] = 1'b0;
            ev[i2csq_pkg::IRQ_SEQ_DONE] = 1'b1;
          end
        end
        default: next_st = i2csq_pkg::ST_IDLE;
      endcase
    end
    // Slave side: byte capture, general call, stretching
    if (!master) begin
      if (scl_d && scl_s && sda_d && !sda_s) begin
        next_s_active = 1'b1;
        next_s_first = 1'b1;
        next_s_cnt = 4'd0;
      end else if (scl_d && scl_s && !sda_d && sda_s) begin
        next_s_active = 1'b0;
      end else if (s_active && !scl_d && scl_s) begin
        if (s_cnt == 4'd8) begin
          next_s_cnt = 4'd0;
        end else begin
          next_s_sh = {s_sh[6:0], sda_s};
          next_s_cnt = s_cnt + 4'd1;
          if (s_cnt == 4'd7) begin
            next_s_first = 1'b0;
            ev[i2csq_pkg::IRQ_SLAVE_BYTE] = 1'b1;
            if (s_first && ctrl[i2csq_pkg::BIT_GENERAL_CALL_ENABLE] &&
                {s_sh[6:0], sda_s} == i2csq_pkg::GENERAL_CALL_ADDR) begin
              ev[i2csq_pkg::IRQ_GCALL] = 1'b1;
            end
          end
        end
      end
      if (s_active && s_cnt == 4'd8 && scl_d && !scl_s && ctrl[i2csq_pkg::BIT_START_OR_STRETCH_ENABLE]) begin
        next_stretch = 1'b1;
      end
      if (rd && avs_address == i2csq_pkg::ADDR_RX_BUF) next_stretch = 1'b0;
      if (wr && avs_address == i2csq_pkg::ADDR_TX_BUF) next_stretch = 1'b0;
    end else begin
      next_stretch = 1'b0;
      next_s_active = 1'b0;
    end
    if (!master && ev[i2csq_pkg::IRQ_SLAVE_BYTE]) next_rx_buf = {s_sh[6:0], sda_s};
    next_irq_stat = irq_stat;
    if (rd && avs_address == i2csq_pkg::ADDR_IRQ_STATUS) next_irq_stat = 4'h0;
    next_irq_stat = next_irq_stat | ev;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= i2csq_pkg::SEQ_CTRL_RESET;
      master <= 1'b0;
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      rdata <= 32'h0000_0000;
      ack_phase <= 1'b0;
      st <= i2csq_pkg::ST_IDLE;
      ph <= 2'd0;
      bitn <= 4'd0;
      shreg <= 8'h00;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      s_cnt <= 4'd0;
      s_sh <= 8'h00;
      s_active <= 1'b0;
      s_first <= 1'b0;
      stretch <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      master <= next_master;
      tx_buf <= next_tx_buf;
      rx_buf <= next_rx_buf;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      ack_phase <= next_ack_phase;
      st <= next_st;
      ph <= next_ph;
      bitn <= next_bitn;
      shreg <= next_shreg;
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
      s_cnt <= next_s_cnt;
      s_sh <= next_s_sh;
      s_active <= next_s_active;
      s_first <= next_s_first;
      stretch <= next_stretch;
    end
  end
endmodule : i2csq_top

/* tb/i2csq_checker.sv */
// Checker: port properties of the sequence control block
`timescale 1ns/10ps
module i2csq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  logic master;
  logic stretch;
  logic next_master;
  logic next_stretch;
  logic wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest;
  // Mode and slave stretch setting as software last wrote them
  always_comb begin
    next_master = master;
    next_stretch = stretch;
    if (wr_ok && avs_address == i2csq_pkg::ADDR_MODE) next_master = avs_writedata[0];
    if (wr_ok && avs_address == i2csq_pkg::ADDR_SEQ_CTRL) next_stretch = avs_writedata[0];
    if (next_master) next_stretch = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      master <= 1'b0;
      stretch <= 1'b0;
    end else begin
      master <= next_master;
      stretch <= next_stretch;
    end
  end
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000) else $error("upper read bits not zero");
  a_wait_one: assert property (@(posedge clk) disable iff (rst)
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
  a_drain_only: assert property (@(posedge clk) disable iff (rst)
    !scl_out && !sda_out) else $error("pin driven high");
  a_start_cond: assert property (@(posedge clk) disable iff (rst)
    master && !scl_oe && !sda_oe && wr_ok && avs_address == i2csq_pkg::ADDR_SEQ_CTRL && avs_writedata[0]
    |-> ##[1:24] (sda_oe && !scl_oe)) else $error("start condition missing");
  a_stop_quiet: assert property (@(posedge clk) disable iff (rst)
    master && $fell(sda_oe) && !scl_oe |-> ##1 (!sda_oe && !scl_oe) [*8]) else $error("bus not idle after stop");
  a_mask_off: assert property (@(posedge clk) disable iff (rst)
    wr_ok && avs_address == i2csq_pkg::ADDR_IRQ_MASK && avs_writedata[3:0] == 4'h0 |-> ##[1:2] !irq)
    else $error("masked interrupt still high");
  a_stretch_off: assert property (@(posedge clk) disable iff (rst)
    !master && !stretch |-> !scl_oe) else $error("clock held without stretch");
  a_slave_quiet: assert property (@(posedge clk) disable iff (rst)
    !master |-> !sda_oe) else $error("data driven in slave mode");
endmodule : i2csq_checker

bind i2csq_top i2csq_checker u_i2csq_checker (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .irq(irq));

/* tb/i2csq_slave_model.sv */
// Far side bus device: slave that acks or sends bytes, and a master for slave mode frames
`timescale 1ns/10ps
module i2csq_slave_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Line pulls
  output logic scl_oe,
  output logic sda_oe,
  // Behaviour
  input wire logic nack,
  input wire logic tx_mode,
  input wire logic [7:0] tx_byte
);
  logic [7:0] rx_byte = 8'h00;
  logic ack_seen = 1'b0;
  logic mastering = 1'b0;
  int cnt = 0;
  int byte_idx = 0;
  int start_count = 0;
  int stop_count = 0;
  initial scl_oe = 1'b0;
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl === 1'b1) begin
    start_count++;
    cnt = 0;
    byte_idx = 0;
  end
  always @(posedge sda) if (scl === 1'b1) stop_count++;
  always @(posedge scl) begin
    if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
    else ack_seen = sda;
    if (cnt == 8) begin
      cnt = 0;
      byte_idx++;
    end else cnt++;
  end
  always @(negedge scl) if (!mastering) begin
    if (tx_mode && byte_idx > 0 && cnt < 8) sda_oe = !tx_byte[7 - cnt];
    else if (cnt == 8 && !(tx_mode && byte_idx > 0)) sda_oe = !nack;
    else sda_oe = 1'b0;
  end
  // Start, eight bits, ack clock and stop at a 48 ns clock
  task send_frame(input logic [7:0] b);
    mastering = 1'b1;
    sda_oe = 1'b1;
    #24;
    for (int i = 0; i < 9; i++) begin
      scl_oe = 1'b1;
      #12;
      sda_oe = (i < 8) ? !b[7 - i] : 1'b0;
      #12;
      scl_oe = 1'b0;
      wait (scl === 1'b1);
      #24;
    end
    scl_oe = 1'b1;
    sda_oe = 1'b1;
    #24;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #24;
    sda_oe = 1'b0;
    #24;
    mastering = 1'b0;
  endtask : send_frame
endmodule : i2csq_slave_model

/* tb/i2csq_top_test.sv */
// Testbench: register table, master sequences, slave general call and stretching
`timescale 1ns/10ps
module i2csq_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_out;
  logic scl_oe;
  logic sda_out;
  logic sda_oe;
  logic irq;
  logic m_scl_oe;
  logic m_sda_oe;
  logic nack = 1'b0;
  logic tx_mode = 1'b0;
  logic [7:0] tx_byte = 8'h96;
  logic [31:0] rd;
  int fail_count = 0;
  int total_checks = 0;
  wire scl_line = !(scl_oe || m_scl_oe);
  wire sda_line = !(sda_oe || m_sda_oe);
  logic [31:0] rows [0:5][0:2] = '{'{32'h5, 32'h0F, 32'h0F}, '{32'h5, 32'h00, 32'h00}, '{32'h7, 32'hFF, 32'h00},
    '{32'hF, 32'h5A, 32'h00}, '{32'h0, 32'hFFFFFFA0, 32'hA0}, '{32'h0, 32'h40, 32'h00}};
  initial forever #2 clk = ~clk;
  i2csq_top #(.QUARTER(4)) u_i2csq_top (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2csq_slave_model u_i2csq_slave_model (.scl(scl_line), .sda(sda_line), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe),
    .nack(nack), .tx_mode(tx_mode), .tx_byte(tx_byte));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) check("waitrequest", 32'h1, 32'h0);
  endtask : bus
  // Reads until bit b of register a is clear
  task poll(input logic [3:0] a, input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 200);
    check("bit clears", {31'h0, rd[b]}, 32'h0);
  endtask : poll
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
  initial begin
    int base;
    logic d;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) if (i != 2 && i != 3) begin
      bus(1'b0, i[3:0], 32'h0);
      check("reset value", rd, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, rows[i][0][3:0], rows[i][1]);
      bus(1'b0, rows[i][0][3:0], 32'h0);
      check("register", rd, rows[i][2]);
    end
    bus(1'b1, i2csq_pkg::ADDR_MODE, 32'h1);
    base = u_i2csq_slave_model.start_count;
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h1);
    poll(i2csq_pkg::ADDR_SEQ_CTRL, i2csq_pkg::BIT_START_OR_STRETCH_ENABLE);
    check("start seen", u_i2csq_slave_model.start_count, base + 1);
    bus(1'b1, i2csq_pkg::ADDR_TX_BUF, 32'hA4);
    bus(1'b1, i2csq_pkg::ADDR_TX_BUF, 32'h11);
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h2);
    poll(i2csq_pkg::ADDR_BUSY, 0);
    check("byte sent", u_i2csq_slave_model.rx_byte, 32'hA4);
    check("no queued start", u_i2csq_slave_model.start_count, base + 1);
    for (int k = 0; k < 2; k++) begin
      nack <= k[0];
      bus(1'b1, i2csq_pkg::ADDR_TX_BUF, 32'h3C);
      poll(i2csq_pkg::ADDR_BUSY, 0);
      bus(1'b0, i2csq_pkg::ADDR_SEQ_CTRL, 32'h0);
      check("ack status", {31'h0, rd[i2csq_pkg::BIT_ACK_STATUS]}, k);
    end
    tx_mode <= 1'b1;
    bus(1'b1, i2csq_pkg::ADDR_IRQ_MASK, 32'h2);
    bus(1'b0, i2csq_pkg::ADDR_IRQ_STATUS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      d = (k == 0);
      bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h8);
      poll(i2csq_pkg::ADDR_SEQ_CTRL, i2csq_pkg::BIT_RECEIVE_ENABLE);
      check("rx irq", {31'h0, irq}, 32'h1);
      bus(1'b0, i2csq_pkg::ADDR_RX_BUF, 32'h0);
      check("rx byte", rd, 32'h96);
      bus(1'b0, i2csq_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("rx status", {31'h0, rd[i2csq_pkg::IRQ_RX_DONE]}, 32'h1);
      @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, {26'h0, d, 5'h00});
      bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, {26'h0, d, 5'h10});
      poll(i2csq_pkg::ADDR_SEQ_CTRL, i2csq_pkg::BIT_ACK_SEQUENCE_ENABLE);
      check("ack sent", {31'h0, u_i2csq_slave_model.ack_seen}, {31'h0, d});
    end
    tx_mode <= 1'b0;
    base = u_i2csq_slave_model.start_count;
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h2);
    poll(i2csq_pkg::ADDR_SEQ_CTRL, i2csq_pkg::BIT_REPEATED_START_ENABLE);
    check("repeated start", u_i2csq_slave_model.start_count, base + 1);
    base = u_i2csq_slave_model.stop_count;
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h4);
    poll(i2csq_pkg::ADDR_SEQ_CTRL, i2csq_pkg::BIT_STOP_ENABLE);
    check("stop", u_i2csq_slave_model.stop_count, base + 1);
    bus(1'b1, i2csq_pkg::ADDR_MODE, 32'h0);
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h81);
    bus(1'b1, i2csq_pkg::ADDR_IRQ_MASK, 32'h4);
    bus(1'b0, i2csq_pkg::ADDR_IRQ_STATUS, 32'h0);
    fork
      u_i2csq_slave_model.send_frame(8'h00);
      begin
        repeat (150) @(posedge clk);
        check("clock held", {31'h0, scl_oe}, 32'h1);
        check("call irq", {31'h0, irq}, 32'h1);
        bus(1'b0, i2csq_pkg::ADDR_RX_BUF, 32'h0);
        check("slave byte", rd, 32'h0);
      end
    join
    bus(1'b0, i2csq_pkg::ADDR_IRQ_STATUS, 32'h0);
    check("call status", {31'h0, rd[i2csq_pkg::IRQ_GCALL]}, 32'h1);
    bus(1'b1, i2csq_pkg::ADDR_SEQ_CTRL, 32'h0);
    u_i2csq_slave_model.send_frame(8'h00);
    bus(1'b0, i2csq_pkg::ADDR_IRQ_STATUS, 32'h0);
    check("call ignored", {31'h0, rd[i2csq_pkg::IRQ_GCALL]}, 32'h0);
    print_verdict;
  end
endmodule : i2csq_top_test
